// [hw/sacc_pkg.sv]
// Purpose: shared constants and types for the search accelerator and configuration block
// Assumes: byte-wide host stream, one slot request at a time on the bus side
// Notes:   register offsets are byte addresses of 32-bit words
package sacc_pkg;

  // ****************************************************
  // register map
  // ****************************************************
  localparam logic [3:0] SACC_OFS_CTRL   = 4'h0;
  localparam logic [3:0] SACC_OFS_STATUS = 4'h4;
  localparam logic [3:0] SACC_OFS_CONFIG = 4'h8;
  localparam int         SACC_CTRL_SRCH  = 0;
  localparam int         SACC_ST_BUSY    = 0;
  localparam int         SACC_ST_ERR     = 1;
  localparam int         SACC_ST_POS_LSB = 2;

  // ****************************************************
  // command byte layout
  // ****************************************************
  localparam int         SACC_CMD_TOP      = 7;
  localparam int         SACC_CMD_LSB      = 0;
  localparam int         SACC_CMD_PAR_HI   = 6;
  localparam int         SACC_CMD_PAR_LO   = 4;
  localparam int         SACC_CMD_VAL_HI   = 3;
  localparam int         SACC_CMD_VAL_LO   = 1;
  localparam int         SACC_CMD_SRCH_BIT = 4;
  localparam logic [2:0] SACC_SRCH_TOP     = 3'h5;
  localparam logic [1:0] SACC_SRCH_LOW     = 2'h1;
  localparam logic [7:0] SACC_CMD_PSTOP    = 8'hf1;
  localparam int         SACC_POS_PER_BYTE = 4;
  localparam int         SACC_BAUD_INV_BIT = 2;

  // ****************************************************
  // parameter codes
  // ****************************************************
  localparam logic [2:0] SACC_PAR_RDSEL = 3'h0;
  localparam logic [2:0] SACC_PAR_SLEW  = 3'h1;
  localparam logic [2:0] SACC_PAR_PPD   = 3'h2;
  localparam logic [2:0] SACC_PAR_SPUD  = 3'h3;
  localparam logic [2:0] SACC_PAR_W1LT  = 3'h4;
  localparam logic [2:0] SACC_PAR_DSO   = 3'h5;
  localparam logic [2:0] SACC_PAR_LOAD  = 3'h6;
  localparam logic [2:0] SACC_PAR_BAUD  = 3'h7;

  // ****************************************************
  // reset values of the value codes
  // ****************************************************
  localparam logic [2:0] SACC_RST_SLEW = 3'h0;  // 15 V/us
  localparam logic [2:0] SACC_RST_PPD  = 3'h4;  // 512 us
  localparam logic [2:0] SACC_RST_SPUD = 3'h4;  // 524 ms
  localparam logic [2:0] SACC_RST_W1LT = 3'h0;  // 8 us standard
  localparam logic [2:0] SACC_RST_DSO  = 3'h0;  // 3 us
  localparam logic [2:0] SACC_RST_LOAD = 3'h0;
  localparam logic [2:0] SACC_RST_BAUD = 3'h0;  // 9.6 kbps

  typedef struct packed {
    logic [2:0] slew;
    logic [2:0] ppd;
    logic [2:0] spud;
    logic [2:0] w1lt;
    logic [2:0] dso;
    logic [2:0] load;
    logic [2:0] baud;
  } sacc_cfg_t;

  localparam sacc_cfg_t SACC_CFG_RST = '{SACC_RST_SLEW, SACC_RST_PPD, SACC_RST_SPUD,
                                         SACC_RST_W1LT, SACC_RST_DSO, SACC_RST_LOAD, SACC_RST_BAUD};

  typedef struct packed {
    logic req;
    logic wr;
    logic wbit;
  } sacc_slot_t;

endpackage

// [hw/sacc_sync2.sv]
// Purpose: two-stage synchroniser for an asynchronous level
// Assumes: input is a slow level, no pulse shorter than two clocks
// Notes:   first stage is read only by the second
`timescale 1ns/10ps
module sacc_sync2 (
  input  wire logic clk_i,   // system clock
  input  wire logic rst_i,   // sync reset, high
  input  wire logic d_i,     // async level
  output logic      q_o      // synchronised level
);
  logic meta_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= 1'b0;
      q_o    <= 1'b0;
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
endmodule

// [hw/sacc_decide.sv]
// Purpose: per-position decision of the search write slot
// Assumes: both read slots of the position are known
// Notes:   pure combinational
`timescale 1ns/10ps
module sacc_decide (
  input  wire logic rd_a_i,   // first read slot
  input  wire logic rd_b_i,   // second read slot
  input  wire logic path_i,   // host path choice
  input  wire logic err_i,    // bus error seen earlier
  output logic      wbit_o,   // value for write slot
  output logic      disc_o,   // discrepancy flag
  output logic      err_o     // error after this position
);
  logic conflict;
  logic absent;

  always_comb begin
    conflict = ~rd_a_i & ~rd_b_i;
    absent   = rd_a_i & rd_b_i;
    disc_o   = conflict | absent;
    err_o    = err_i | absent;
    if (err_o) begin
      wbit_o = 1'b1;
    end else if (conflict) begin
      wbit_o = path_i;
    end else begin
      wbit_o = rd_a_i;
    end
  end
endmodule

// [hw/sacc_top.sv]
// Purpose: search accelerator and configuration parameter store of a serial to single-wire master
// Assumes: host bytes arrive already deframed with a command/data mode flag on this clock
// Notes:   slot timing and edge shaping live outside; this block only orders slots and holds codes
//
// Design decisions made here: the register addresses and register access over Avalon-MM.
`timescale 1ns/10ps
module sacc_top (
  input  wire logic        SYS_CLK_I,               // 100 MHz clock
  input  wire logic        SYS_RST_I,               // sync reset, high
  input  wire logic [3:0]  AVS_ADDRESS_I,           // byte address
  input  wire logic        AVS_READ_I,              // read strobe
  input  wire logic        AVS_WRITE_I,             // write strobe
  input  wire logic [31:0] AVS_WRITEDATA_I,         // write data
  input  wire logic [3:0]  AVS_BYTEENABLE_I,        // byte lanes
  output logic [31:0]      AVS_READDATA_O,          // read data
  output logic             AVS_WAITREQUEST_O,       // stall
  input  wire logic        HOST_RX_VALID_I,         // host byte strobe
  input  wire logic [7:0]  HOST_RX_DATA_I,          // host byte
  input  wire logic        HOST_RX_CMD_MODE_I,      // 1 command mode, 0 data mode
  output logic             HOST_RX_READY_O,         // block can take a byte
  output logic             HOST_TX_VALID_O,         // response strobe
  output logic [7:0]       HOST_TX_DATA_O,          // response byte
  output logic [2:0]       HOST_BAUD_CODE_O,        // rate code for the host link
  input  wire logic        POLARITY_SELECT_PIN_I,   // async polarity strap
  output logic             RX_POLARITY_O,           // effective receive polarity
  output sacc_pkg::sacc_slot_t SLOT_O,              // slot request, kind, write value
  input  wire logic        SLOT_DONE_I,             // slot finished pulse
  input  wire logic        SLOT_RBIT_I,             // sampled bit at done
  output sacc_pkg::sacc_cfg_t CFG_O,                // current value codes
  output logic             SEARCH_ON_O,             // search flag
  output logic             PULSE_STOP_O             // end pulse request
);
  import sacc_pkg::*;

  // ****************************************************
  // state
  // ****************************************************
  typedef enum logic [4:0] {
    SACC_S_IDLE  = 5'b00001,
    SACC_S_RDA   = 5'b00010,
    SACC_S_RDB   = 5'b00100,
    SACC_S_WR    = 5'b01000,
    SACC_S_EMIT  = 5'b10000
  } sacc_state_t;

  sacc_state_t state_r;
  sacc_state_t state_nxt;
  sacc_cfg_t   cfg_r;
  logic        srch_r;
  logic        err_r;
  logic [7:0]  path_r;
  logic [7:0]  resp_r;
  logic [1:0]  sub_r;
  logic [5:0]  pos_r;
  logic        rda_r;
  logic        pol_sync;
  logic        wbit;
  logic        disc;
  logic        err_nxt;
  logic        path_bit;

  // ****************************************************
  // host byte decode
  // ****************************************************
  logic       rx_take;
  logic       cmd_cfg;
  logic       cmd_rd;
  logic       cmd_srch;
  logic       cmd_stop;
  logic       data_srch;
  logic [2:0] par_code;
  logic [2:0] val_code;
  logic [2:0] rd_code;
  logic [2:0] cur_val;

  assign rx_take   = HOST_RX_VALID_I & HOST_RX_READY_O;
  assign par_code  = HOST_RX_DATA_I[SACC_CMD_PAR_HI:SACC_CMD_PAR_LO];
  assign val_code  = HOST_RX_DATA_I[SACC_CMD_VAL_HI:SACC_CMD_VAL_LO];
  assign rd_code   = val_code;
  assign cmd_cfg   = rx_take & HOST_RX_CMD_MODE_I & ~HOST_RX_DATA_I[SACC_CMD_TOP]
                   & HOST_RX_DATA_I[SACC_CMD_LSB];
  assign cmd_rd    = cmd_cfg & (par_code == SACC_PAR_RDSEL);
  assign cmd_srch  = rx_take & HOST_RX_CMD_MODE_I & (HOST_RX_DATA_I[7:5] == SACC_SRCH_TOP)
                   & (HOST_RX_DATA_I[1:0] == SACC_SRCH_LOW);
  assign cmd_stop  = rx_take & HOST_RX_CMD_MODE_I & (HOST_RX_DATA_I == SACC_CMD_PSTOP);
  assign data_srch = rx_take & ~HOST_RX_CMD_MODE_I & srch_r;

  always_comb begin
    unique case (rd_code)
      SACC_PAR_SLEW: cur_val = cfg_r.slew;
      SACC_PAR_PPD:  cur_val = cfg_r.ppd;
      SACC_PAR_SPUD: cur_val = cfg_r.spud;
      SACC_PAR_W1LT: cur_val = cfg_r.w1lt;
      SACC_PAR_DSO:  cur_val = cfg_r.dso;
      SACC_PAR_LOAD: cur_val = cfg_r.load;
      SACC_PAR_BAUD: cur_val = cfg_r.baud;
      default:       cur_val = 3'h0;
    endcase
  end

  // ****************************************************
  // configuration store
  // ****************************************************
  // value codes are stored as sent; strong pullup code 110 is the host's to avoid
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      cfg_r <= SACC_CFG_RST;
    end else if (cmd_cfg && !cmd_rd) begin
      unique case (par_code)
        SACC_PAR_SLEW: cfg_r.slew <= val_code;
        SACC_PAR_PPD:  cfg_r.ppd  <= val_code;
        SACC_PAR_SPUD: cfg_r.spud <= val_code;
        SACC_PAR_W1LT: cfg_r.w1lt <= val_code;
        SACC_PAR_DSO:  cfg_r.dso  <= val_code;
        SACC_PAR_LOAD: cfg_r.load <= val_code;
        SACC_PAR_BAUD: cfg_r.baud <= val_code;
        default:       cfg_r.load <= cfg_r.load;
      endcase
    end
  end

  assign CFG_O            = cfg_r;
  assign HOST_BAUD_CODE_O = cfg_r.baud;

  // ****************************************************
  // polarity
  // ****************************************************
  sacc_sync2 u_pol_sync (
    .clk_i (SYS_CLK_I),
    .rst_i (SYS_RST_I),
    .d_i   (POLARITY_SELECT_PIN_I),
    .q_o   (pol_sync)
  );

  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      RX_POLARITY_O <= 1'b0;
    end else begin
      RX_POLARITY_O <= pol_sync ^ cfg_r.baud[SACC_BAUD_INV_BIT];
    end
  end

  // ****************************************************
  // pulse stop
  // ****************************************************
  // data-mode F1h is a plain byte, so only the command path can stop a pulse
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      PULSE_STOP_O <= 1'b0;
    end else begin
      PULSE_STOP_O <= cmd_stop;
    end
  end

  // ****************************************************
  // search flag and error latch
  // ****************************************************
  logic bus_wr_ctrl;

  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      srch_r <= 1'b0;
    end else if (cmd_srch) begin
      srch_r <= HOST_RX_DATA_I[SACC_CMD_SRCH_BIT];
    end else if (bus_wr_ctrl && state_r == SACC_S_IDLE) begin
      srch_r <= AVS_WRITEDATA_I[SACC_CTRL_SRCH];
    end
  end

  assign SEARCH_ON_O = srch_r;

  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I || !srch_r) begin
      err_r <= 1'b0;
    end else if (state_r == SACC_S_RDB && SLOT_DONE_I) begin
      err_r <= err_nxt;
    end
  end

  // ****************************************************
  // search sequencer
  // ****************************************************
  assign path_bit = path_r[2 * sub_r + 1];

  sacc_decide u_decide (
    .rd_a_i (rda_r),
    .rd_b_i (SLOT_RBIT_I),
    .path_i (path_bit),
    .err_i  (err_r),
    .wbit_o (wbit),
    .disc_o (disc),
    .err_o  (err_nxt)
  );

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      SACC_S_IDLE: if (data_srch) state_nxt = SACC_S_RDA;
      SACC_S_RDA:  if (SLOT_DONE_I) state_nxt = SACC_S_RDB;
      SACC_S_RDB:  if (SLOT_DONE_I) state_nxt = SACC_S_WR;
      SACC_S_WR: begin
        if (SLOT_DONE_I) begin
          state_nxt = (sub_r == 2'(SACC_POS_PER_BYTE - 1)) ? SACC_S_EMIT : SACC_S_RDA;
        end
      end
      SACC_S_EMIT: state_nxt = SACC_S_IDLE;
      default:     state_nxt = SACC_S_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      state_r <= SACC_S_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      path_r <= 8'h00;
      sub_r  <= 2'h0;
      rda_r  <= 1'b0;
    end else begin
      if (data_srch) begin
        path_r <= HOST_RX_DATA_I;
        sub_r  <= 2'h0;
      end
      if (state_r == SACC_S_RDA && SLOT_DONE_I) begin
        rda_r <= SLOT_RBIT_I;
      end
      if (state_r == SACC_S_WR && SLOT_DONE_I) begin
        sub_r <= sub_r + 2'h1;
      end
    end
  end

  // position counter restarts whenever search is switched off
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I || !srch_r) begin
      pos_r <= 6'h00;
    end else if (state_r == SACC_S_WR && SLOT_DONE_I) begin
      pos_r <= pos_r + 6'h01;
    end
  end

  // slot request held until the slot engine reports done
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      SLOT_O <= '0;
    end else if (SLOT_DONE_I || (state_r == SACC_S_IDLE && !data_srch)) begin
      SLOT_O.req <= 1'b0;
      if (state_r == SACC_S_RDA) begin
        SLOT_O <= '{req: 1'b1, wr: 1'b0, wbit: 1'b1};
      end else if (state_r == SACC_S_RDB) begin
        SLOT_O <= '{req: 1'b1, wr: 1'b1, wbit: wbit};
      end else if (state_r == SACC_S_WR && sub_r != 2'(SACC_POS_PER_BYTE - 1)) begin
        SLOT_O <= '{req: 1'b1, wr: 1'b0, wbit: 1'b1};
      end
    end else if (data_srch) begin
      SLOT_O <= '{req: 1'b1, wr: 1'b0, wbit: 1'b1};
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      resp_r <= 8'h00;
    end else if (state_r == SACC_S_RDB && SLOT_DONE_I) begin
      resp_r[2 * sub_r]     <= disc;
      resp_r[2 * sub_r + 1] <= wbit;
    end
  end

  // ****************************************************
  // host response
  // ****************************************************
  // baud register updates in the same edge as the strobe, so the echo leaves at the new rate
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      HOST_TX_VALID_O <= 1'b0;
      HOST_TX_DATA_O  <= 8'h00;
    end else begin
      HOST_TX_VALID_O <= 1'b0;
      if (cmd_rd) begin
        HOST_TX_VALID_O <= 1'b1;
        HOST_TX_DATA_O  <= {HOST_RX_DATA_I[7:4], cur_val, 1'b0};
      end else if (cmd_cfg) begin
        HOST_TX_VALID_O <= 1'b1;
        HOST_TX_DATA_O  <= {HOST_RX_DATA_I[7:1], 1'b0};
      end else if (state_r == SACC_S_EMIT) begin
        HOST_TX_VALID_O <= 1'b1;
        HOST_TX_DATA_O  <= resp_r;
      end
    end
  end

  // one byte per search step; no input buffer, so the host link is stalled instead
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      HOST_RX_READY_O <= 1'b1;
    end else begin
      HOST_RX_READY_O <= (state_nxt == SACC_S_IDLE) && !data_srch;
    end
  end

  // ****************************************************
  // register bus slave
  // ****************************************************
  logic bus_req;

  assign bus_req     = (AVS_READ_I | AVS_WRITE_I) & AVS_WAITREQUEST_O;
  assign bus_wr_ctrl = bus_req & AVS_WRITE_I & (AVS_ADDRESS_I == SACC_OFS_CTRL) & AVS_BYTEENABLE_I[0];

  // one wait cycle per access; writes act on the edge that raises the answer
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      AVS_WAITREQUEST_O <= 1'b1;
    end else if (!AVS_WAITREQUEST_O) begin
      AVS_WAITREQUEST_O <= 1'b1;
    end else if (AVS_READ_I || AVS_WRITE_I) begin
      AVS_WAITREQUEST_O <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      AVS_READDATA_O <= 32'h0000_0000;
    end else if (bus_req && AVS_READ_I) begin
      unique case (AVS_ADDRESS_I)
        SACC_OFS_CTRL:   AVS_READDATA_O <= {31'h0000_0000, srch_r};
        SACC_OFS_STATUS: AVS_READDATA_O <= {24'h00_0000, pos_r, err_r, ~(state_r == SACC_S_IDLE)};
        SACC_OFS_CONFIG: AVS_READDATA_O <= {11'h000, cfg_r};
        default:         AVS_READDATA_O <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// [verif/sacc_assertions.sv]
// Purpose: port-level checks of the search accelerator and config block
// Assumes: single clock, synchronous active-high reset
// Notes:   write value is judged only where the two reads or an earlier error decide it
`timescale 1ns/10ps
module sacc_assertions (
  input wire logic       SYS_CLK_I,              // clock
  input wire logic       SYS_RST_I,              // reset
  input wire logic       HOST_RX_VALID_I,        // host strobe
  input wire logic [7:0] HOST_RX_DATA_I,         // host byte
  input wire logic       HOST_RX_CMD_MODE_I,     // command mode
  input wire logic       HOST_RX_READY_O,        // ready
  input wire logic       HOST_TX_VALID_O,        // response strobe
  input wire logic [7:0] HOST_TX_DATA_O,         // response byte
  input wire logic [2:0] HOST_BAUD_CODE_O,       // rate code
  input wire logic       POLARITY_SELECT_PIN_I,  // strap
  input wire logic       RX_POLARITY_O,          // rx polarity
  input wire sacc_pkg::sacc_slot_t SLOT_O,       // slot request
  input wire logic       SLOT_DONE_I,            // slot done
  input wire logic       SLOT_RBIT_I,            // read value
  input wire logic       SEARCH_ON_O,            // search flag
  input wire logic       PULSE_STOP_O            // stop pulse
);
  import sacc_pkg::*;
  logic [1:0] ph_r;
  logic       ra_r;
  logic       rb_r;
  logic       err_r;

  // ******
  // slot phase tracking
  // ******
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I || !SEARCH_ON_O) begin
      ph_r  <= 2'h0;
      err_r <= 1'b0;
    end else if (SLOT_DONE_I && SLOT_O.req) begin
      ph_r <= (ph_r == 2'h2) ? 2'h0 : ph_r + 2'h1;
      if (ph_r == 2'h1 && ra_r && SLOT_RBIT_I) err_r <= 1'b1;
    end
  end
  always_ff @(posedge SYS_CLK_I) begin
    if (SLOT_DONE_I && ph_r == 2'h0) ra_r <= SLOT_RBIT_I;
    if (SLOT_DONE_I && ph_r == 2'h1) rb_r <= SLOT_RBIT_I;
  end

  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  sequence s_take;
    HOST_RX_VALID_I && HOST_RX_READY_O && HOST_RX_CMD_MODE_I;
  endsequence
  sequence s_cfg;
    s_take ##0 !HOST_RX_DATA_I[7] && HOST_RX_DATA_I[0];
  endsequence
  sequence s_sctl;
    s_take ##0 HOST_RX_DATA_I[7:5] == SACC_SRCH_TOP && HOST_RX_DATA_I[1:0] == SACC_SRCH_LOW;
  endsequence

  AST_SLOT_HOLD: assert property (SLOT_O.req && !SLOT_DONE_I |=> SLOT_O.req && $stable(SLOT_O))
    else $error("slot request changed before done");
  AST_SLOT_ORDER: assert property (SLOT_O.req |-> SLOT_O.wr == (ph_r == 2'h2))
    else $error("slot kind out of order");
  AST_WBIT: assert property (SLOT_O.req && ph_r == 2'h2 && (err_r || ra_r != rb_r) |-> SLOT_O.wbit == (err_r || ra_r))
    else $error("wrong write slot value");
  AST_CFG_RESP: assert property (s_cfg |=> HOST_TX_VALID_O && !HOST_TX_DATA_O[0]
    && HOST_TX_DATA_O[7:4] == $past(HOST_RX_DATA_I[7:4])
    && ($past(HOST_RX_DATA_I[6:4]) == 3'h0 || HOST_TX_DATA_O[3:1] == $past(HOST_RX_DATA_I[3:1])))
    else $error("bad config response");
  AST_BAUD_NEW: assert property (s_cfg ##0 HOST_RX_DATA_I[6:4] == SACC_PAR_BAUD |=>
    HOST_TX_VALID_O && HOST_BAUD_CODE_O == $past(HOST_RX_DATA_I[3:1]))
    else $error("response not at new rate");
  AST_POL: assert property (($stable(POLARITY_SELECT_PIN_I) && $stable(HOST_BAUD_CODE_O))[*5] |->
    RX_POLARITY_O == (POLARITY_SELECT_PIN_I ^ HOST_BAUD_CODE_O[2]))
    else $error("rx polarity wrong");
  AST_PSTOP: assert property (PULSE_STOP_O == $past(HOST_RX_VALID_I && HOST_RX_READY_O
    && HOST_RX_CMD_MODE_I && HOST_RX_DATA_I == SACC_CMD_PSTOP))
    else $error("pulse stop mismatch");
  AST_SRCH_CTRL: assert property (s_sctl |=>
    SEARCH_ON_O == $past(HOST_RX_DATA_I[SACC_CMD_SRCH_BIT]) && !HOST_TX_VALID_O)
    else $error("search control wrong");
endmodule

bind sacc_top sacc_assertions i_chk (.*);

// [verif/sacc_wire_model.sv]
// Purpose: wired-and slave population answering slot requests
// Assumes: one request at a time, 64 positions per pass
// Notes:   rbit toggles outside done so a stale bit is never reused
`timescale 1ns/10ps
module sacc_wire_model (
  input  wire logic        clk_i,    // clock
  input  wire logic        rst_i,    // reset
  input  wire sacc_pkg::sacc_slot_t slot_i,   // slot request
  input  wire logic [63:0] rom_a_i,  // first slave id
  input  wire logic [63:0] rom_b_i,  // second slave id
  input  wire logic [1:0]  ndev_i,   // slaves present
  input  wire logic [3:0]  lat_i,    // slot length
  output logic             done_o,   // slot done
  output logic             rbit_o    // read value
);
  import sacc_pkg::*;
  logic [3:0] cnt_r;
  logic [1:0] ph_r;
  logic [5:0] pos_r;
  logic       a_on_r;
  logic       b_on_r;
  logic       ba;
  logic       bb;

  assign ba = rom_a_i[pos_r];
  assign bb = rom_b_i[pos_r];
  always @(posedge clk_i) begin
    if (rst_i) begin
      {done_o, rbit_o, cnt_r, ph_r, pos_r} <= '0;
    end else if (done_o || !slot_i.req || cnt_r != lat_i) begin
      done_o <= 1'b0;
      rbit_o <= !rbit_o;
      cnt_r  <= (done_o || !slot_i.req) ? 4'h0 : cnt_r + 4'h1;
      // population reloads only between passes
      if (!slot_i.req && pos_r == 6'h0 && ph_r == 2'h0) begin
        a_on_r <= ndev_i != 2'h0;
        b_on_r <= ndev_i[1];
      end
    end else begin
      done_o <= 1'b1;
      ph_r   <= (ph_r == 2'h2) ? 2'h0 : ph_r + 2'h1;
      rbit_o <= (ph_r == 2'h0) ? ((!a_on_r | ba) & (!b_on_r | bb)) : ((!a_on_r | !ba) & (!b_on_r | !bb));
      if (ph_r == 2'h2) begin
        a_on_r <= a_on_r & (ba == slot_i.wbit);
        b_on_r <= b_on_r & (bb == slot_i.wbit);
        pos_r  <= pos_r + 6'h1;
      end
    end
  end
endmodule

// [verif/tb.sv]
// Purpose: self-checking bench for sacc_top
// Assumes: host bytes arrive deframed, slot engine replaced by a model
// Notes:   config rows first, then bus, polarity and search passes
`timescale 1ns/10ps
module tb;
  import sacc_pkg::*;
  typedef struct packed {logic [7:0] cmd; logic [7:0] rsp;} sacc_row_t;
  logic         clk, rst, rd, wr, rx_v, rx_cmd, pin, done, rbit, ack, tx_v, rdy, polarity_select_pin, son, pstop;
  logic [3:0]   adr, lat;
  logic [31:0]  wd, rdd, q;
  logic [7:0]   rx_d, tx_d;
  logic [8:0]   r;
  logic [2:0]   baud;
  logic [1:0]   ndev;
  logic [63:0]  path;
  logic [127:0] got;
  sacc_slot_t   slot;
  sacc_cfg_t    cfg;
  int           n_errors, checks, m;
  int           n_stop = 0;
  logic [63:0]  rom_a = 64'h6e21_0c94_b3f7_5a08;
  logic [63:0]  rom_b = 64'h9e21_0d94_b3f6_5a18;
  sacc_row_t    rows [16] = '{'{8'h13, 8'h12}, '{8'h2d, 8'h2c}, '{8'h3b, 8'h3a}, '{8'h45, 8'h44},
    '{8'h57, 8'h56}, '{8'h6d, 8'h6c}, '{8'h79, 8'h78}, '{8'h03, 8'h02}, '{8'h05, 8'h0c}, '{8'h07, 8'h0a},
    '{8'h09, 8'h04}, '{8'h0b, 8'h06}, '{8'h0d, 8'h0c}, '{8'h0f, 8'h08}, '{8'h01, 8'h00}, '{8'h71, 8'h70}};

  sacc_top i_dut (.SYS_CLK_I(clk), .SYS_RST_I(rst), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
    .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(4'hf), .AVS_READDATA_O(rdd), .AVS_WAITREQUEST_O(ack),
    .HOST_RX_VALID_I(rx_v), .HOST_RX_DATA_I(rx_d), .HOST_RX_CMD_MODE_I(rx_cmd), .HOST_RX_READY_O(rdy),
    .HOST_TX_VALID_O(tx_v), .HOST_TX_DATA_O(tx_d), .HOST_BAUD_CODE_O(baud), .POLARITY_SELECT_PIN_I(pin),
    .RX_POLARITY_O(polarity_select_pin), .SLOT_O(slot), .SLOT_DONE_I(done), .SLOT_RBIT_I(rbit), .CFG_O(cfg),
    .SEARCH_ON_O(son), .PULSE_STOP_O(pstop));
  sacc_wire_model i_wire (.clk_i(clk), .rst_i(rst), .slot_i(slot), .rom_a_i(rom_a), .rom_b_i(rom_b),
    .ndev_i(ndev), .lat_i(lat), .done_o(done), .rbit_o(rbit));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(negedge clk) if (pstop === 1'b1) n_stop++;

  // ******
  // helpers
  // ******
  task automatic end_sim;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k = 0;
    @(posedge clk);
    {rd, wr, adr, wd} <= {!w, w, a, d};
    do begin @(posedge clk); k++; end while (ack !== 1'b0 && k < 50);
    if (ack !== 1'b0) begin n_errors++; end_sim(); end
    q = rdd;
    {rd, wr} <= 2'h0;
  endtask
  task automatic send(input logic cm, input logic [7:0] b, input int wt);
    int k = 0;
    do begin @(negedge clk); k++; end while (rdy !== 1'b1 && k < 900);
    if (rdy !== 1'b1) begin n_errors++; end_sim(); end
    @(posedge clk);
    {rx_v, rx_d, rx_cmd} <= {1'b1, b, cm};
    @(posedge clk);
    rx_v <= 1'b0;
    r = {1'b0, 8'hxx};
    for (k = 0; k < wt; k++) begin
      @(negedge clk);
      if (tx_v === 1'b1) begin r = {1'b1, tx_d}; k = wt; end
    end
  endtask
  function automatic logic [127:0] exp_pass(input logic [63:0] p, input logic [1:0] nd, input logic e);
    logic a, b, x, y, w;
    logic [127:0] res;
    a = nd != 2'h0;
    b = nd[1];
    for (int n = 0; n < 64; n++) begin
      x = (!a | rom_a[n]) & (!b | rom_b[n]);
      y = (!a | !rom_a[n]) & (!b | !rom_b[n]);
      e = e | (x & y);
      w = e | ((x != y) ? x : p[n]);
      res[2*n +: 2] = {w, x == y};
      a = a & (rom_a[n] == w);
      b = b & (rom_b[n] == w);
    end
    return res;
  endfunction
  task automatic run_pass(input logic e, input string nm);
    logic [7:0] b;
    for (int i = 0; i < 16; i++) begin
      b = 8'h55;  // filler bits set on purpose, must be ignored
      for (int k = 0; k < 4; k++) b[2*k+1] = path[4*i+k];
      send(1'b0, b, 600);
      got[8*i +: 8] = r[7:0];
    end
    chk(nm, exp_pass(path, ndev, e), got);
  endtask

  // ******
  // main sequence
  // ******
  initial begin
    {rst, rd, wr, rx_v, rx_cmd, pin} = 6'h20;
    {adr, wd, rx_d, lat} = 48'h0;
    ndev = 2'h2;
    n_errors = 0;
    checks = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("cfg_reset", SACC_CFG_RST, cfg);
    chk("search_reset", 0, son);
    foreach (rows[i]) begin
      send(1'b1, rows[i].cmd, 4);
      chk("cfg_rsp", {1'b1, rows[i].rsp}, r);
    end
    bus(1'b0, SACC_OFS_CONFIG, 0);
    chk("config_reg", sacc_cfg_t'{3'h1, 3'h6, 3'h5, 3'h2, 3'h3, 3'h6, 3'h0}, q[20:0]);
    bus(1'b0, 4'hc, 0);
    chk("unmapped", 0, q);
    bus(1'b1, SACC_OFS_CTRL, 1);
    chk("ctrl_on", 1, son);
    bus(1'b1, SACC_OFS_CTRL, 0);
    chk("ctrl_off", 0, son);
    for (int i = 0; i < 3; i++) begin
      if (i == 1) pin <= 1'b1;
      send(1'b1, (i == 2) ? 8'h71 : 8'h7f, 4);
      repeat (6) @(negedge clk);
      chk("rx_pol", i != 1, polarity_select_pin);
    end
    send(1'b1, SACC_CMD_PSTOP, 4);
    send(1'b0, SACC_CMD_PSTOP, 4);
    chk("stop_count", 1, n_stop);
    send(1'b0, 8'h33, 20);
    chk("plain_byte", 0, r[8]);
    send(1'b1, 8'hb1, 4);
    chk("srch_on", 2'h1, {r[8], son});
    path = '0;
    run_pass(1'b0, "pass1");
    for (int n = 0; n < 64; n++) if (got[2*n]) m = n;
    for (int n = 0; n < 64; n++) if (n > m) path[n] = 1'b0;
    path[m] = 1'b1;
    lat = 4'h5;
    run_pass(1'b0, "pass2");
    {ndev, lat} = {2'h0, 4'h0};
    run_pass(1'b0, "absent");
    bus(1'b0, SACC_OFS_STATUS, 0);
    chk("status_err", 32'(1) << SACC_ST_ERR, q);
    ndev = 2'h2;
    run_pass(1'b1, "after_err");
    send(1'b1, 8'ha1, 4);
    chk("srch_off", 0, {r[8], son});
    end_sim();
  end
endmodule
